// >>> design/sdn_ack_ctrl.sv
// Acknowledge decision for received bytes, with the forced data refusal.
`timescale 1ns/1ns
module sdn_ack_ctrl
   import sdn_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic reset,
   // Settings.
   sdn_cfg_if.ack    cfg,
   // Protocol engine side.
   input  wire logic slave_rx_role,
   input  wire logic rx_byte_done,
   input  wire logic rx_data_phase,
   input  wire logic normal_ack,
   // Decision outputs.
   output logic      rx_ack,
   output logic      rx_push,
   output logic      rx_abort
);

   logic ack_q;
   logic push_q;
   logic abort_q;

   // Refusal is forced only on data bytes taken as slave receiver.
   wire  force_nack = cfg.reject_bit & slave_rx_role & rx_data_phase;
   // Otherwise the ordinary criteria decide.
   wire  ack_d      = force_nack ? 1'b0 : normal_ack;
   wire  push_d     = rx_byte_done & slave_rx_role & rx_data_phase & ack_d;
   wire  abort_d    = rx_byte_done & force_nack;

   // Latch the decision per byte and pulse push or abort for one cycle.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ack_q   <= 1'b0;
         push_q  <= 1'b0;
         abort_q <= 1'b0;
      end
      else
      begin
         if (rx_byte_done)
            ack_q <= ack_d;
         push_q  <= push_d;
         abort_q <= abort_d;
      end
   end

   assign rx_ack   = ack_q;
   assign rx_push  = push_q;
   assign rx_abort = abort_q;

endmodule : sdn_ack_ctrl

// >>> design/sdn_cfg_if.sv
// Interface that carries the programmed settings from the register file to the two engines.
`timescale 1ns/1ns
interface sdn_cfg_if;
   import sdn_pkg::*;

   // Settings driven by the register file.
   logic            reject_bit;
   logic            tx_dma_enable;
   logic            rx_dma_enable;
   logic [WM_W-1:0] tx_watermark_level;
   logic [WM_W-1:0] rx_watermark_level;

   // The acknowledge engine only needs the reject bit.
   modport ack (
      input reject_bit
   );

   // The DMA engine needs the channel enables and watermarks.
   modport dma (
      input tx_dma_enable,
      input rx_dma_enable,
      input tx_watermark_level,
      input rx_watermark_level
   );
endinterface : sdn_cfg_if

// >>> design/sdn_dma_req.sv
// Watermark comparison that raises the transmit and receive DMA requests.
`timescale 1ns/1ns
module sdn_dma_req
   import sdn_pkg::*;
#(
   parameter int LEVEL_W = 5
)
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               reset,
   // Settings.
   sdn_cfg_if.dma                  cfg,
   // FIFO fill levels.
   input  wire logic [LEVEL_W-1:0] tx_level,
   input  wire logic [LEVEL_W-1:0] rx_level,
   // Requests to the DMA controller.
   output logic                    tx_req,
   output logic                    rx_req
);

   logic tx_req_q;
   logic rx_req_q;

   // Watermarks widened to the level width for comparison.
   wire [LEVEL_W-1:0] tx_wm = {{(LEVEL_W-WM_W){1'b0}}, cfg.tx_watermark_level};
   wire [LEVEL_W-1:0] rx_wm = {{(LEVEL_W-WM_W){1'b0}}, cfg.rx_watermark_level};
   wire tx_req_d = cfg.tx_dma_enable & (tx_level <= tx_wm);
   // At least watermark plus one entries equals strictly more than the watermark.
   wire rx_req_d = cfg.rx_dma_enable & (rx_level > rx_wm);

   // Requests are recomputed every clock and drop when either term fails.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx_req_q <= 1'b0;
         rx_req_q <= 1'b0;
      end
      else
      begin
         tx_req_q <= tx_req_d;
         rx_req_q <= rx_req_d;
      end
   end

   assign tx_req = tx_req_q;
   assign rx_req = rx_req_q;

endmodule : sdn_dma_req

// >>> design/sdn_pkg.sv
// Constants, register map and field layout of the slave data reject and DMA request block.
// Function
// - With the reject bit set in the slave-receiver role, every data byte is refused, the transfer aborts and the byte is not pushed.
// - With the reject bit clear the ordinary acknowledge decision is used, and the bit resets to zero.
// - A write to the reject register lands only while the controller is disabled and the slave-activity status reads zero.
// - When the reject option is built out, the reject register is absent and writes to it do nothing.
// - The forced refusal acts only in the slave-receiver role and leaves every other role untouched.
// - The DMA enable register takes writes at any time, enabled or not.
// - Bit one of the DMA enable register turns the transmit channel on, and it resets to zero.
// - Bit zero of the DMA enable register turns the receive channel on, and it resets to zero.
// - The transmit request is raised while enabled and the transmit level is at or below the watermark.
// - The receive request is raised while enabled and the receive level is at least the watermark plus one.
package sdn_pkg;

   // ******************************************************************
   // Bus geometry.
   // ******************************************************************
   localparam int         ADR_W            = 8;
   localparam int         DAT_W            = 32;
   localparam int         SEL_W            = 4;
   localparam int         WM_W             = 4;

   // ******************************************************************
   // Register byte offsets.
   // ******************************************************************
   localparam logic [7:0] OFF_REJECT       = 8'h84;
   localparam logic [7:0] OFF_DMA_EN       = 8'h88;
   localparam logic [7:0] OFF_TX_WM        = 8'h8c;
   localparam logic [7:0] OFF_RX_WM        = 8'h90;
   localparam logic [7:0] OFF_STATUS       = 8'ha0;

   // ******************************************************************
   // Field positions.
   // ******************************************************************
   localparam int         REJECT_BIT       = 0;
   localparam int         RX_DMA_EN_BIT    = 0;
   localparam int         TX_DMA_EN_BIT    = 1;
   localparam int         WM_LSB           = 0;
   localparam int         STAT_ENABLE_BIT  = 0;
   localparam int         STAT_SLV_ACT_BIT = 6;
   localparam int         STAT_TX_REQ_BIT  = 8;
   localparam int         STAT_RX_REQ_BIT  = 9;
   localparam int         STAT_REFUSED_BIT = 16;

   // ******************************************************************
   // Reset values.
   // ******************************************************************
   localparam logic            RST_REJECT  = 1'b0;
   localparam logic            RST_DMA_EN  = 1'b0;
   localparam logic [WM_W-1:0] RST_WM      = 4'h0;
   localparam logic [DAT_W-1:0] ZERO_WORD  = 32'h0000_0000;

endpackage : sdn_pkg

// >>> design/sdn_top.sv
// Top of the slave data reject and DMA request block with its Wishbone register file.
`timescale 1ns/1ns
module sdn_top
   import sdn_pkg::*;
#(
   parameter int LEVEL_W     = 5,
   parameter bit SLV_NACK_EN = 1'b1
)
(
   // Clock and reset.
   clk,
   reset,
   // Wishbone classic slave.
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_adr_i,
   wb_sel_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o,
   // Controller state from the protocol engine.
   ctrl_enable,
   slave_activity,
   // Received byte handling.
   slave_rx_role,
   rx_byte_done,
   rx_data_phase,
   normal_ack,
   rx_ack,
   rx_push,
   rx_abort,
   // FIFO levels and DMA requests.
   tx_level,
   rx_level,
   tx_dma_req,
   rx_dma_req
);

   // ******************************************************************
   // Port declarations.
   // ******************************************************************

   // Clock and reset.
   input  wire logic               clk;
   input  wire logic               reset;
   // Wishbone classic slave.
   input  wire logic               wb_cyc_i;
   input  wire logic               wb_stb_i;
   input  wire logic               wb_we_i;
   input  wire logic [ADR_W-1:0]   wb_adr_i;
   input  wire logic [SEL_W-1:0]   wb_sel_i;
   input  wire logic [DAT_W-1:0]   wb_dat_i;
   output logic      [DAT_W-1:0]   wb_dat_o;
   output logic                    wb_ack_o;
   // Controller state from the protocol engine.
   input  wire logic               ctrl_enable;
   input  wire logic               slave_activity;
   // Received byte handling.
   input  wire logic               slave_rx_role;
   input  wire logic               rx_byte_done;
   input  wire logic               rx_data_phase;
   input  wire logic               normal_ack;
   output logic                    rx_ack;
   output logic                    rx_push;
   output logic                    rx_abort;
   // FIFO levels and DMA requests.
   input  wire logic [LEVEL_W-1:0] tx_level;
   input  wire logic [LEVEL_W-1:0] rx_level;
   output logic                    tx_dma_req;
   output logic                    rx_dma_req;

   // ******************************************************************
   // Elaboration checks.
   // ******************************************************************

   // The level must hold every watermark and stay a sensible width.
   generate
      if (LEVEL_W < WM_W || LEVEL_W > 16)
      begin : g_bad_level
         $error("sdn_top: LEVEL_W must lie between 4 and 16");
      end
   endgenerate

   // ******************************************************************
   // Register state.
   // ******************************************************************

   logic             ack_q;
   logic             ack_d;
   logic [DAT_W-1:0] rdata_q;
   logic [DAT_W-1:0] rdata_d;
   logic             reject_q;
   logic             reject_d;
   logic             tx_en_q;
   logic             tx_en_d;
   logic             rx_en_q;
   logic             rx_en_d;
   logic [WM_W-1:0]  tx_wm_q;
   logic [WM_W-1:0]  tx_wm_d;
   logic [WM_W-1:0]  rx_wm_q;
   logic [WM_W-1:0]  rx_wm_d;
   logic             refused_q;
   logic             refused_d;
   logic             tx_req_w;
   logic             rx_req_w;

   // ******************************************************************
   // Bus decode.
   // ******************************************************************

   // A request is served once; ack_q masks the second cycle of a held strobe.
   wire bus_req    = wb_cyc_i & wb_stb_i & ~ack_q;
   wire bus_wr     = bus_req & wb_we_i;
   wire bus_rd     = bus_req & ~wb_we_i;
   // All writable fields sit in the lowest byte lane, except the refused flag clear in lane two.
   wire lane0_wr   = bus_wr & wb_sel_i[0];
   wire lane2_wr   = bus_wr & wb_sel_i[2];

   // Word address compare; the two low address bits are ignored.
   wire hit_reject = SLV_NACK_EN & (wb_adr_i[ADR_W-1:2] == OFF_REJECT[ADR_W-1:2]);
   wire hit_dma_en = wb_adr_i[ADR_W-1:2] == OFF_DMA_EN[ADR_W-1:2];
   wire hit_tx_wm  = wb_adr_i[ADR_W-1:2] == OFF_TX_WM[ADR_W-1:2];
   wire hit_rx_wm  = wb_adr_i[ADR_W-1:2] == OFF_RX_WM[ADR_W-1:2];
   wire hit_status = wb_adr_i[ADR_W-1:2] == OFF_STATUS[ADR_W-1:2];

   // ******************************************************************
   // Write qualification.
   // ******************************************************************

   // The reject bit is guarded by enable and slave activity.
   wire reject_idle   = ~ctrl_enable & ~slave_activity;
   wire reject_wr     = lane0_wr & hit_reject;
   wire reject_wr_ok  = reject_wr & reject_idle;
   wire reject_wr_bad = reject_wr & ~reject_idle;
   // DMA enables and watermarks take writes at any time.
   wire dma_en_wr     = lane0_wr & hit_dma_en;
   wire tx_wm_wr      = lane0_wr & hit_tx_wm;
   wire rx_wm_wr      = lane0_wr & hit_rx_wm;
   // Writing one to the refused flag clears it.
   wire refused_clr   = lane2_wr & hit_status & wb_dat_i[STAT_REFUSED_BIT];

   // ******************************************************************
   // Next register values.
   // ******************************************************************

   // Reject bit stays zero when the option is built out.
   assign reject_d  = ~SLV_NACK_EN ? RST_REJECT :
                      reject_wr_ok ? wb_dat_i[REJECT_BIT] : reject_q;
   // Channel enables.
   assign tx_en_d   = dma_en_wr ? wb_dat_i[TX_DMA_EN_BIT] : tx_en_q;
   assign rx_en_d   = dma_en_wr ? wb_dat_i[RX_DMA_EN_BIT] : rx_en_q;
   // Watermarks.
   assign tx_wm_d   = tx_wm_wr ? wb_dat_i[WM_LSB +: WM_W] : tx_wm_q;
   assign rx_wm_d   = rx_wm_wr ? wb_dat_i[WM_LSB +: WM_W] : rx_wm_q;
   // A refused write sets the flag, and the set wins over a clear.
   assign refused_d = reject_wr_bad | (refused_q & ~refused_clr);
   // Ack rises for one cycle per request.
   assign ack_d     = bus_req;

   // ******************************************************************
   // Read multiplexer.
   // ******************************************************************

   // Words of each register with reserved bits at zero.
   wire [DAT_W-1:0] reject_word = {{(DAT_W-1){1'b0}}, reject_q};
   wire [DAT_W-1:0] dma_en_word = {{(DAT_W-2){1'b0}}, tx_en_q, rx_en_q};
   wire [DAT_W-1:0] tx_wm_word  = {{(DAT_W-WM_W){1'b0}}, tx_wm_q};
   wire [DAT_W-1:0] rx_wm_word  = {{(DAT_W-WM_W){1'b0}}, rx_wm_q};

   // Status word mirrors live controller state and the request outputs.
   logic [DAT_W-1:0] status_word;
   always_comb
   begin
      status_word                   = ZERO_WORD;
      status_word[STAT_ENABLE_BIT]  = ctrl_enable;
      status_word[STAT_SLV_ACT_BIT] = slave_activity;
      status_word[STAT_TX_REQ_BIT]  = tx_req_w;
      status_word[STAT_RX_REQ_BIT]  = rx_req_w;
      status_word[STAT_REFUSED_BIT] = refused_q;
   end

   // Unmapped and absent addresses read as zero.
   wire [DAT_W-1:0] rd_word = hit_reject ? reject_word :
                              hit_dma_en ? dma_en_word :
                              hit_tx_wm  ? tx_wm_word  :
                              hit_rx_wm  ? rx_wm_word  :
                              hit_status ? status_word : ZERO_WORD;
   // Read data is captured with the ack and held until the next read.
   assign rdata_d = bus_rd ? rd_word : rdata_q;

   // ******************************************************************
   // Register flops.
   // ******************************************************************

   // Bus answer flops.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ack_q   <= 1'b0;
         rdata_q <= ZERO_WORD;
      end
      else
      begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // Control register flops.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reject_q  <= RST_REJECT;
         tx_en_q   <= RST_DMA_EN;
         rx_en_q   <= RST_DMA_EN;
         tx_wm_q   <= RST_WM;
         rx_wm_q   <= RST_WM;
         refused_q <= 1'b0;
      end
      else
      begin
         reject_q  <= reject_d;
         tx_en_q   <= tx_en_d;
         rx_en_q   <= rx_en_d;
         tx_wm_q   <= tx_wm_d;
         rx_wm_q   <= rx_wm_d;
         refused_q <= refused_d;
      end
   end

   // ******************************************************************
   // Settings to the engines.
   // ******************************************************************

   sdn_cfg_if cfg ();

   // The interface carries the registered settings.
   assign cfg.reject_bit         = reject_q;
   assign cfg.tx_dma_enable      = tx_en_q;
   assign cfg.rx_dma_enable      = rx_en_q;
   assign cfg.tx_watermark_level = tx_wm_q;
   assign cfg.rx_watermark_level = rx_wm_q;

   // ******************************************************************
   // Engines.
   // ******************************************************************

   // Acknowledge decision for each received byte.
   sdn_ack_ctrl u_ack (
      .clk           (clk),
      .reset         (reset),
      .cfg           (cfg),
      .slave_rx_role (slave_rx_role),
      .rx_byte_done  (rx_byte_done),
      .rx_data_phase (rx_data_phase),
      .normal_ack    (normal_ack),
      .rx_ack        (rx_ack),
      .rx_push       (rx_push),
      .rx_abort      (rx_abort)
   );

   // Watermark comparison for the DMA handshake.
   sdn_dma_req #(
      .LEVEL_W (LEVEL_W)
   ) u_dma (
      .clk      (clk),
      .reset    (reset),
      .cfg      (cfg),
      .tx_level (tx_level),
      .rx_level (rx_level),
      .tx_req   (tx_req_w),
      .rx_req   (rx_req_w)
   );

   // ******************************************************************
   // Outputs.
   // ******************************************************************

   // Bus answer and requests come straight from flops.
   assign wb_ack_o   = ack_q;
   assign wb_dat_o   = rdata_q;
   assign tx_dma_req = tx_req_w;
   assign rx_dma_req = rx_req_w;

endmodule : sdn_top

// >>> testbench/sdn_far_model.sv
// Far side model: a DMA controller moving FIFO entries and a remote master sending bytes.
`timescale 1ns/1ns
module sdn_far_model
#(
   parameter int LEVEL_W = 5
)
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               reset,
   // Bench control.
   input  wire logic               load,
   input  wire logic [LEVEL_W-1:0] tx_set,
   input  wire logic [LEVEL_W-1:0] rx_set,
   input  wire logic               serve,
   input  wire logic               byte_go,
   input  wire logic               byte_data,
   // Block side.
   input  wire logic               tx_dma_req,
   input  wire logic               rx_dma_req,
   output logic      [LEVEL_W-1:0] tx_level,
   output logic      [LEVEL_W-1:0] rx_level,
   output logic                    rx_byte_done,
   output logic                    rx_data_phase
);
   logic slow_q;
   // The DMA side moves one entry every other cycle, so it lags the requests.
   // Outside a byte the phase line toggles, so nothing may lean on a stale value.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         {tx_level, rx_level, rx_byte_done, rx_data_phase, slow_q} <= '0;
      end
      else
      begin
         slow_q <= ~slow_q;
         rx_byte_done <= byte_go;
         rx_data_phase <= byte_go ? byte_data : ~rx_data_phase;
         if (load)
            {tx_level, rx_level} <= {tx_set, rx_set};
         else if (serve && slow_q)
         begin
            if (tx_dma_req && ~&tx_level)
               tx_level <= tx_level + 1'b1;
            if (rx_dma_req && |rx_level)
               rx_level <= rx_level - 1'b1;
         end
      end
   end
endmodule : sdn_far_model

// >>> testbench/sdn_properties.sv
// Checker with the timing relations of the reject and DMA request block.
`timescale 1ns/1ns
module sdn_properties
   import sdn_pkg::*;
#(
   parameter int LEVEL_W     = 5,
   parameter bit SLV_NACK_EN = 1'b1
)
(
   // Clock and reset.
   input wire logic               clk,
   input wire logic               reset,
   // Register bus.
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_we_i,
   input wire logic [ADR_W-1:0]   wb_adr_i,
   input wire logic [SEL_W-1:0]   wb_sel_i,
   input wire logic [DAT_W-1:0]   wb_dat_i,
   input wire logic               wb_ack_o,
   // Controller state and received bytes.
   input wire logic               ctrl_enable,
   input wire logic               slave_activity,
   input wire logic               slave_rx_role,
   input wire logic               rx_byte_done,
   input wire logic               rx_data_phase,
   input wire logic               normal_ack,
   input wire logic               rx_ack,
   input wire logic               rx_push,
   input wire logic               rx_abort,
   // Levels and requests.
   input wire logic [LEVEL_W-1:0] tx_level,
   input wire logic [LEVEL_W-1:0] rx_level,
   input wire logic               tx_dma_req,
   input wire logic               rx_dma_req
);
   // ****
   // Shadow copy of the settings.
   // ****
   logic            rej_q;
   logic            tx_en_q;
   logic            rx_en_q;
   logic [WM_W-1:0] tx_wm_q;
   logic [WM_W-1:0] rx_wm_q;
   // A write is taken on an edge with the strobe up and no pending answer.
   wire wr_w    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   wire tx_want = tx_en_q && (tx_level <= LEVEL_W'(tx_wm_q));
   wire rx_want = rx_en_q && (rx_level > LEVEL_W'(rx_wm_q));
   // The reject copy only moves under the same guard the block must apply.
   always_ff @(posedge clk)
   begin
      if (reset)
         {rej_q, tx_en_q, rx_en_q, tx_wm_q, rx_wm_q} <= '0;
      else if (wr_w)
      begin
         if (wb_adr_i == OFF_REJECT && SLV_NACK_EN && !ctrl_enable && !slave_activity)
            rej_q <= wb_dat_i[0];
         if (wb_adr_i == OFF_DMA_EN)
            {tx_en_q, rx_en_q} <= wb_dat_i[1:0];
         if (wb_adr_i == OFF_TX_WM)
            tx_wm_q <= wb_dat_i[3:0];
         if (wb_adr_i == OFF_RX_WM)
            rx_wm_q <= wb_dat_i[3:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing");
   forced_nack_a: assert property (
      rx_byte_done && rej_q && slave_rx_role && rx_data_phase |=> !rx_ack && rx_abort && !rx_push)
      else $error("forced refusal not applied");
   normal_ack_a: assert property (
      rx_byte_done && !(rej_q && slave_rx_role && rx_data_phase)
      |=> rx_ack == $past(normal_ack) && !rx_abort) else $error("ordinary ack lost");
   push_data_a: assert property (
      rx_byte_done && !rej_q && slave_rx_role && rx_data_phase && normal_ack |=> rx_push)
      else $error("accepted byte not pushed");
   role_guard_a: assert property (rx_byte_done && !slave_rx_role |=> !rx_push && !rx_abort)
      else $error("refusal outside receiver role");
   idle_hold_a: assert property (!rx_byte_done |=> $stable(rx_ack) && !rx_push && !rx_abort)
      else $error("byte outputs moved without a byte");
   tx_request_a: assert property (1'b1 |=> tx_dma_req == $past(tx_want))
      else $error("transmit request wrong");
   rx_request_a: assert property (1'b1 |=> rx_dma_req == $past(rx_want))
      else $error("receive request wrong");
   // Main scenarios reached.
   cover property (rx_abort);
   cover property (tx_dma_req && rx_dma_req);
   cover property (wb_ack_o && rej_q);
endmodule : sdn_properties

bind sdn_top sdn_properties #(.LEVEL_W(LEVEL_W), .SLV_NACK_EN(SLV_NACK_EN)) sdn_properties_i (
   .clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
   .ctrl_enable, .slave_activity, .slave_rx_role, .rx_byte_done, .rx_data_phase, .normal_ack,
   .rx_ack, .rx_push, .rx_abort, .tx_level, .rx_level, .tx_dma_req, .rx_dma_req);

// >>> testbench/sdn_tb_top.sv
// Self-checking bench for the slave data reject and DMA request block.
`timescale 1ns/1ns
module sdn_tb_top;
   import sdn_pkg::*;
   localparam int LW = 5;
   logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = '0;
   logic [31:0] wdat = '0, dat1, dat2, rd, rd2, r;
   logic ack, ctrl_enable = 1'b0, slave_activity = 1'b0, slave_rx_role = 1'b0, normal_ack = 1'b0;
   logic load = 1'b0, serve = 1'b0, byte_go = 1'b0, byte_data = 1'b0, done, phase;
   logic rx_ack, rx_push, rx_abort, tx_req, rx_req;
   logic [LW-1:0] tx_set = '0, rx_set = '0, tx_level, rx_level;
   logic [1:0] en;
   logic [3:0] wt, wr;
   logic [7:0] offs [5] = '{OFF_REJECT, OFF_DMA_EN, OFF_TX_WM, OFF_RX_WM, 8'h40};
   int error_cnt = 0;
   int samples_checked = 0;
   always #2 clk = ~clk;
   sdn_top #(.LEVEL_W(LW), .SLV_NACK_EN(1'b1)) sdn_top_i (.clk, .reset, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat1), .wb_ack_o(ack), .ctrl_enable, .slave_activity, .slave_rx_role,
      .rx_byte_done(done), .rx_data_phase(phase), .normal_ack, .rx_ack, .rx_push, .rx_abort,
      .tx_level, .rx_level, .tx_dma_req(tx_req), .rx_dma_req(rx_req));
   // Same block built without the reject register, sharing all inputs.
   sdn_top #(.LEVEL_W(LW), .SLV_NACK_EN(1'b0)) sdn_top_bare_i (.clk, .reset, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat2), .wb_ack_o(), .ctrl_enable, .slave_activity, .slave_rx_role,
      .rx_byte_done(done), .rx_data_phase(phase), .normal_ack, .rx_ack(), .rx_push(),
      .rx_abort(), .tx_level, .rx_level, .tx_dma_req(), .rx_dma_req());
   sdn_far_model #(.LEVEL_W(LW)) sdn_far_model_i (.clk, .reset, .load, .tx_set, .rx_set, .serve,
      .byte_go, .byte_data, .tx_dma_req(tx_req), .rx_dma_req(rx_req), .tx_level, .rx_level,
      .rx_byte_done(done), .rx_data_phase(phase));
   // Compares one value and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One classic bus cycle; ack and read data are taken at the rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      chk("bus answer", n < 50, 1'b1);
      rd = dat1;
      rd2 = dat2;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask : bus
   // Expected acknowledge, push and abort for one received byte.
   function automatic logic [2:0] exp_byte(input logic rej, role, data, na);
      logic f;
      f = rej & role & data;
      return {~f & na, ~f & role & data & na, f};
   endfunction : exp_byte
   // Lets the model take new levels and the block answer them.
   task automatic settle();
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      @(posedge clk);
      #1;
   endtask : settle
   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Cuts a hang short.
   initial
   begin
      #200000;
      error_cnt++;
      close_out();
   end
   // ****
   // Main sequence.
   // ****
   initial
   begin
      void'($urandom(4538));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      foreach (offs[k])
      begin
         bus(1'b0, offs[k], '0);
         chk("reset value", rd, '0);
      end
      for (int i = 0; i < 40; i++)
      begin
         r = $urandom;
         {en, wt, wr} = r[9:0];
         ctrl_enable <= r[31];
         bus(1'b1, OFF_DMA_EN, {r[31:2], en});
         bus(1'b1, OFF_TX_WM, {r[31:4], wt});
         bus(1'b1, OFF_RX_WM, {r[31:4], wr});
         bus(1'b0, OFF_DMA_EN, '0);
         chk("dma enables", rd, {30'h0, en});
         tx_set <= i[0] ? LW'(wt) + LW'(i[1]) : LW'($urandom);
         rx_set <= i[0] ? LW'(wr) + LW'(i[2]) : LW'($urandom);
         settle();
         chk("tx request", tx_req, en[1] && tx_level <= LW'(wt));
         chk("rx request", rx_req, en[0] && rx_level > LW'(wr));
         @(posedge clk);
      end
      ctrl_enable <= 1'b0;
      bus(1'b1, OFF_DMA_EN, 32'h3);
      bus(1'b1, OFF_TX_WM, 32'h5);
      bus(1'b1, OFF_RX_WM, 32'h2);
      {tx_set, rx_set} <= {LW'(0), LW'(15)};
      settle();
      @(posedge clk) serve <= 1'b1;
      repeat (60) @(posedge clk);
      serve <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("tx filled", {tx_level > LW'(5), tx_req}, 2'b10);
      chk("rx drained", {rx_level <= LW'(2), rx_req}, 2'b10);
      @(posedge clk);
      for (int k = 0; k < 2; k++)
      begin
         {ctrl_enable, slave_activity} <= k ? 2'b01 : 2'b10;
         bus(1'b1, OFF_REJECT, 32'h1);
         bus(1'b0, OFF_REJECT, '0);
         chk("guarded reject", rd, '0);
      end
      slave_activity <= 1'b0;
      bus(1'b0, OFF_STATUS, '0);
      chk("slave activity", rd[STAT_SLV_ACT_BIT], 1'b0);
      chk("status word", rd, 32'h1 << STAT_REFUSED_BIT);
      bus(1'b1, OFF_STATUS, 32'h1 << STAT_REFUSED_BIT);
      bus(1'b0, OFF_STATUS, '0);
      chk("refused cleared", rd, '0);
      for (int k = 0; k < 2; k++)
      begin
         bus(1'b1, OFF_REJECT, {31'h0, !k[0]});
         bus(1'b0, OFF_REJECT, '0);
         chk("reject bit", rd, {31'h0, !k[0]});
         chk("absent reject", rd2, '0);
         for (int c = 0; c < 8; c++)
         begin
            {slave_rx_role, byte_data, normal_ack, byte_go} <= {c[2:0], 1'b1};
            @(posedge clk);
            byte_go <= 1'b0;
            @(posedge clk);
            #1;
            chk("byte decision", {rx_ack, rx_push, rx_abort},
                exp_byte(!k[0], c[2], c[1], c[0]));
            @(posedge clk);
         end
      end
      close_out();
   end
endmodule : sdn_tb_top
